/* hdl/mpm_pin_mode.sv */
`timescale 1ns/1ps
module mpm_pin_mode
(
   // Clock and reset
   input  wire logic                   CLK_SYS,
   input  wire logic                   SYS_RST,
   // Straps
   input  wire logic                   BOOT_MODE_STRAP,
   input  wire logic                   HOST_INTERFACE_SELECT,
   input  wire logic                   ADDR_LSB_SELECT,
   // Core status and control
   input  wire logic                   BOOT_DONE,
   input  wire logic                   MOTION_EVENT,
   input  wire logic                   IRQ_FIRST,
   input  wire logic                   IRQ_SECOND,
   input  wire logic                   PIN2_TRIGGER_MODE,
   input  wire mpm_pkg::mpm_pin_type_t IRQ_FIRST_TYPE,
   input  wire mpm_pkg::mpm_pin_type_t IRQ_SECOND_TYPE,
   input  wire logic                   TYPE_WRITE,
   input  wire logic                   SPI_THREE_WIRE,
   input  wire logic                   SPI_MISO_DATA,
   input  wire logic                   SPI_MISO_ACTIVE,
   input  wire logic                   SERIAL_SDA_DATA,
   input  wire logic                   SERIAL_SDA_OE,
   input  wire logic                   HIB_REQUEST,
   // Pins
   input  wire logic                   CS_N_PIN,
   input  wire logic                   PIN1_IN,
   output logic                        PIN1_O,
   output logic                        PIN1_OE,
   input  wire logic                   PIN2_IN,
   output logic                        PIN2_O,
   output logic                        PIN2_OE,
   output logic                        MISO_O,
   output logic                        MISO_OE,
   output logic                        SDA_O,
   output logic                        SDA_OE,
   // Status to core
   output logic                        MOTION_MODE,
   output logic                        SPI_SELECTED,
   output logic                        I2C_ADDR_LSB,
   output logic                        CHIP_SELECT,
   output logic                        MEASURE_TRIGGER,
   output logic                        MOTION_DETECT_EN,
   output logic                        HIBERNATE,
   output logic                        WAKE
);
   typedef enum logic [1:0] {ST_ACTIVE, ST_PULSE, ST_HIBERNATE} mpm_state_t;

   mpm_state_t                     state;
   logic                           strap_taken;
   logic                           motion_mode;
   logic                           spi_sel;
   logic                           cs_n_s;
   logic                           pin1_s;
   logic                           pin2_s;
   logic                           cs_n_q;
   logic [mpm_pkg::CNT_W-1:0]      low_cnt;
   logic [mpm_pkg::CNT_W-1:0]      pulse_cnt;
   logic                           long_low;
   logic                           wake_req;
   mpm_pkg::mpm_pin_type_t         type1;
   mpm_pkg::mpm_pin_type_t         type2;
   mpm_pkg::mpm_pin_drv_t          drv1;
   mpm_pkg::mpm_pin_drv_t          drv2;
   logic                           hib;
   logic [mpm_pkg::CNT_W-1:0]      pulse_seen;

   // Select and motion line idle high, so reset leaves no false edge or low time
   mpm_sync #(.RST_VAL(mpm_pkg::PIN_IDLE_HIGH)) u_sync_cs
      (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .din(CS_N_PIN), .dout(cs_n_s));
   mpm_sync #(.RST_VAL(mpm_pkg::PIN_IDLE_HIGH)) u_sync_p1
      (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .din(PIN1_IN), .dout(pin1_s));
   mpm_sync u_sync_p2 (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .din(PIN2_IN), .dout(pin2_s));

   // Straps caught on first cycle after reset release, then frozen
   always_ff @(posedge CLK_SYS)
   begin
      if (SYS_RST)
      begin
         strap_taken <= 1'b0;
         motion_mode <= mpm_pkg::BOOT_DEFAULT;
         spi_sel     <= mpm_pkg::IF_I2C;
      end
      else if (!strap_taken)
      begin
         strap_taken <= 1'b1;
         motion_mode <= (BOOT_MODE_STRAP == mpm_pkg::BOOT_MOTION);
         spi_sel     <= (HOST_INTERFACE_SELECT == mpm_pkg::IF_SPI);
      end
   end

   // Address LSB follows the pin only in I2C mode
   always_ff @(posedge CLK_SYS)
   begin
      if (SYS_RST)
         I2C_ADDR_LSB <= 1'b0;
      else
         I2C_ADDR_LSB <= spi_sel ? 1'b0 : ADDR_LSB_SELECT;
   end

   // Motion-line low time
   always_ff @(posedge CLK_SYS)
   begin
      if (SYS_RST)
         low_cnt <= '0;
      else if (!motion_mode || state != ST_ACTIVE || pin1_s)
         low_cnt <= '0;
      else if (!long_low)
         low_cnt <= low_cnt + 1'b1;
   end
   assign long_low = (low_cnt > mpm_pkg::CNT_W'(mpm_pkg::HIB_ENTRY_CYCLES));

   always_ff @(posedge CLK_SYS)
   begin
      cs_n_q <= SYS_RST ? 1'b1 : cs_n_s;
   end
   assign wake_req = !motion_mode && cs_n_q && !cs_n_s;

   // Operating state
   always_ff @(posedge CLK_SYS)
   begin
      if (SYS_RST)
      begin
         state     <= ST_ACTIVE;
         pulse_cnt <= '0;
      end
      else
      begin
         case (state)
            ST_ACTIVE:
            begin
               if (motion_mode && long_low)
                  state <= ST_HIBERNATE;
               else if (!motion_mode && HIB_REQUEST)
                  state <= ST_HIBERNATE;
               else if (motion_mode && pin1_s && MOTION_EVENT)
               begin
                  state     <= ST_PULSE;
                  pulse_cnt <= '0;
               end
            end
            ST_PULSE:
            begin
               if (pulse_cnt == mpm_pkg::CNT_W'(mpm_pkg::MOTION_PULSE_CYCLES - 1))
                  state <= ST_ACTIVE;
               else
                  pulse_cnt <= pulse_cnt + 1'b1;
            end
            ST_HIBERNATE:
            begin
               if (motion_mode ? pin1_s : wake_req)
                  state <= ST_ACTIVE;
            end
            default:
               state <= ST_ACTIVE;
         endcase
      end
   end
   assign hib = (state == ST_HIBERNATE);

   // Interrupt pin types, held at push-pull during reset and for as long as hibernate lasts
   always_ff @(posedge CLK_SYS)
   begin
      if (SYS_RST || hib)
      begin
         type1 <= mpm_pkg::MPM_PIN_PUSH_PULL;
         type2 <= mpm_pkg::MPM_PIN_PUSH_PULL;
      end
      else if (TYPE_WRITE)
      begin
         type1 <= IRQ_FIRST_TYPE;
         type2 <= IRQ_SECOND_TYPE;
      end
   end

   mpm_irq_drv u_drv1
   (
      .pin_type (type1),
      .irq      (IRQ_FIRST),
      .tristate (hib || motion_mode),
      .drv      (drv1)
   );

   mpm_irq_drv u_drv2
   (
      .pin_type (type2),
      .irq      (IRQ_SECOND),
      .tristate (hib || motion_mode || PIN2_TRIGGER_MODE),
      .drv      (drv2)
   );

   // Pin outputs
   always_comb
   begin
      PIN1_O  = drv1.o;
      PIN1_OE = drv1.oe;
      if (motion_mode)
      begin
         PIN1_O  = 1'b0;
         PIN1_OE = (state == ST_PULSE);
      end
      PIN2_O  = drv2.o;
      PIN2_OE = drv2.oe;
      if (motion_mode)
      begin
         PIN2_O  = 1'b0;
         PIN2_OE = !hib && !BOOT_DONE;
      end
      MISO_O  = SPI_MISO_DATA;
      MISO_OE = !hib && spi_sel && !SPI_THREE_WIRE && SPI_MISO_ACTIVE;
      SDA_O   = SERIAL_SDA_DATA;
      SDA_OE  = !hib && SERIAL_SDA_OE;
   end

   assign MOTION_MODE      = motion_mode;
   assign SPI_SELECTED     = spi_sel;
   assign CHIP_SELECT      = spi_sel && !hib && !cs_n_s;
   assign MEASURE_TRIGGER  = !motion_mode && PIN2_TRIGGER_MODE && !hib && pin2_s;
   assign MOTION_DETECT_EN = motion_mode && !hib && pin1_s;
   assign HIBERNATE        = hib;
   assign WAKE             = (state == ST_HIBERNATE) && (motion_mode ? pin1_s : wake_req);

   // Assertions
   property p_strap_hold;
      @(posedge CLK_SYS) disable iff (SYS_RST)
      strap_taken |=> $stable(motion_mode);
   endproperty
   a_strap_hold: assert property (p_strap_hold) else $error("strap changed");

   property p_pin2_od;
      @(posedge CLK_SYS) disable iff (SYS_RST)
      motion_mode && PIN2_OE |-> !PIN2_O;
   endproperty
   a_pin2_od: assert property (p_pin2_od) else $error("pin2 drives high");

   property p_trig_quiet;
      @(posedge CLK_SYS) disable iff (SYS_RST)
      !motion_mode && PIN2_TRIGGER_MODE |-> !PIN2_OE;
   endproperty
   a_trig_quiet: assert property (p_trig_quiet) else $error("trigger pin driven");

   property p_no_wake_motion;
      @(posedge CLK_SYS) disable iff (SYS_RST)
      motion_mode && hib && !pin1_s |=> hib;
   endproperty
   a_no_wake_motion: assert property (p_no_wake_motion) else $error("bad wake");

   // Checker count of the cycles the motion line is pulled low
   always_ff @(posedge CLK_SYS)
   begin
      if (SYS_RST || !(motion_mode && PIN1_OE))
         pulse_seen <= '0;
      else
         pulse_seen <= pulse_seen + 1'b1;
   end

   property p_pulse_len;
      @(posedge CLK_SYS) disable iff (SYS_RST)
      motion_mode && $past(motion_mode) && $fell(PIN1_OE)
         |-> pulse_seen == mpm_pkg::CNT_W'(mpm_pkg::MOTION_PULSE_CYCLES);
   endproperty
   a_pulse_len: assert property (p_pulse_len) else $error("pulse length wrong");

   property p_hib_entry;
      @(posedge CLK_SYS) disable iff (SYS_RST)
      motion_mode && state == ST_ACTIVE && long_low |=> hib;
   endproperty
   a_hib_entry: assert property (p_hib_entry) else $error("no hibernate");

   property p_hib_pins;
      @(posedge CLK_SYS) disable iff (SYS_RST)
      hib |-> !PIN2_OE && !MISO_OE && !SDA_OE && !PIN1_OE;
   endproperty
   a_hib_pins: assert property (p_hib_pins) else $error("pin driven in hibernate");

   property p_type_default;
      @(posedge CLK_SYS) disable iff (SYS_RST)
      $fell(hib) |-> type1 == mpm_pkg::MPM_PIN_PUSH_PULL;
   endproperty
   a_type_default: assert property (p_type_default) else $error("type not reset");

   property p_three_wire;
      @(posedge CLK_SYS) disable iff (SYS_RST)
      SPI_THREE_WIRE |-> !MISO_OE;
   endproperty
   a_three_wire: assert property (p_three_wire) else $error("miso in 3-wire");

   property p_addr;
      @(posedge CLK_SYS) disable iff (SYS_RST)
      strap_taken && !spi_sel |=> I2C_ADDR_LSB == $past(ADDR_LSB_SELECT);
   endproperty
   a_addr: assert property (p_addr) else $error("address lsb wrong");

   c_hib:   cover property (@(posedge CLK_SYS) disable iff (SYS_RST) $rose(hib));
   c_wake:  cover property (@(posedge CLK_SYS) disable iff (SYS_RST) $fell(hib));
   c_pulse: cover property (@(posedge CLK_SYS) disable iff (SYS_RST) $rose(state == ST_PULSE));
endmodule : mpm_pin_mode

/* shared/mpm_pkg.sv */
package mpm_pkg;

   // Boot-mode strap values
   localparam logic BOOT_DEFAULT = 1'b0;
   localparam logic BOOT_MOTION  = 1'b1;

   // Host-interface strap values
   localparam logic IF_I2C = 1'b0;
   localparam logic IF_SPI = 1'b1;

   // Idle level of pins held high by a pull-up or by the host
   localparam logic PIN_IDLE_HIGH = 1'b1;

   // Interrupt pin type encoding
   typedef enum logic [1:0]
   {
      MPM_PIN_PUSH_PULL   = 2'h0,
      MPM_PIN_OPEN_DRAIN  = 2'h1,
      MPM_PIN_OPEN_SOURCE = 2'h2,
      MPM_PIN_INPUT       = 2'h3
   } mpm_pin_type_t;

   // Two-way pin carrier
   typedef struct packed
   {
      logic o;
      logic oe;
   } mpm_pin_drv_t;

   // Timing
   localparam int CLK_HZ               = 40000000;
   localparam int HIB_ENTRY_LOW_US     = 500;
   localparam int MOTION_PULSE_US      = 250;
   localparam int HIB_ENTRY_CYCLES     = (CLK_HZ / 1000000) * HIB_ENTRY_LOW_US;
   localparam int MOTION_PULSE_CYCLES  = (CLK_HZ / 1000000) * MOTION_PULSE_US;
   localparam int CNT_W                = 24;

   // Synchroniser depth
   localparam int SYNC_STAGES = 3;

endpackage : mpm_pkg

/* hdl/mpm_sync.sv */
`timescale 1ns/1ps
module mpm_sync
#(
   // Level held through reset, matching the pin's idle level
   parameter logic RST_VAL = 1'b0
)
(
   // Clock and reset
   input  wire logic CLK_SYS,
   input  wire logic SYS_RST,
   // Data
   input  wire logic din,
   output logic      dout
);
   logic [2:0] stage;

   // Third and second agree before a change is taken
   always_ff @(posedge CLK_SYS)
   begin
      if (SYS_RST)
         stage <= {3{RST_VAL}};
      else
         stage <= {stage[1:0], din};
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (SYS_RST)
         dout <= RST_VAL;
      else if (stage[2] == stage[1])
         dout <= stage[2];
   end
endmodule : mpm_sync

/* hdl/mpm_irq_drv.sv */
`timescale 1ns/1ps
module mpm_irq_drv
(
   // Configuration
   input  wire mpm_pkg::mpm_pin_type_t pin_type,
   input  wire logic                   irq,
   input  wire logic                   tristate,
   // Pin drive
   output mpm_pkg::mpm_pin_drv_t       drv
);
   // Output type shapes only the enable; the driven level is always irq
   always_comb
   begin
      drv.o  = irq;
      drv.oe = 1'b0;
      if (!tristate)
      begin
         case (pin_type)
            mpm_pkg::MPM_PIN_PUSH_PULL:   drv.oe = 1'b1;
            mpm_pkg::MPM_PIN_OPEN_DRAIN:  drv.oe = !irq;
            mpm_pkg::MPM_PIN_OPEN_SOURCE: drv.oe = irq;
            default:                      drv.oe = 1'b0;
         endcase
      end
   end
endmodule : mpm_irq_drv

/* testbench/mpm_host_model.sv */
`timescale 1ns/1ps
module mpm_host_model
(
   // Clock
   input  wire logic                  clk,
   // Host control
   input  wire logic                  wired,
   input  wire logic                  host_low,
   input  wire logic                  ext_en,
   input  wire logic                  ext_val,
   // Device drive
   input  wire mpm_pkg::mpm_pin_drv_t d1,
   input  wire mpm_pkg::mpm_pin_drv_t d2,
   // Resolved lines
   output logic                       l1,
   output logic                       l2
);
   logic r1;
   logic r2;
   logic last2;
   // Pull-up on the motion line, any low driver wins
   assign r1 = !host_low && !(d1.oe && !d1.o);
   // Undriven second pin shows no stale level
   assign r2 = d2.oe ? d2.o : (ext_en ? ext_val : ~last2);
   assign l1 = wired ? (r1 && !(d2.oe && !d2.o)) : r1;
   assign l2 = wired ? l1 : r2;
   always_ff @(posedge clk) last2 <= l2;
endmodule : mpm_host_model

/* testbench/mpm_pin_mode_tb_top.sv */
`timescale 1ns/1ps
module mpm_pin_mode_tb_top;
   logic clk, rst, boot, ifs, sa0, bdone, mev, i1, i2, trg, twr, tw3;
   logic mdat, mact, sdat, soe, hib, csn, wired, hlow, een, ev;
   logic p1i, p1o, p1oe, p2i, p2o, p2oe, mo, moe, so, sdoe;
   logic mm, spi, lsb, cs, mt, mde, hb, wk;
   mpm_pkg::mpm_pin_type_t t1, t2;
   mpm_pkg::mpm_pin_drv_t  d1, d2;
   int err_count = 0;
   int samples_checked = 0;
   int n;
   int m;
   // Rows: irq1, irq2, trigger mode -> pin1 o, pin1 oe, pin2 o, pin2 oe
   logic [6:0] rows [4] = '{7'h05, 7'h4D, 7'h27, 7'h7C};

   assign d1 = {p1o, p1oe};
   assign d2 = {p2o, p2oe};

   mpm_pin_mode DUT
   (
      .CLK_SYS(clk), .SYS_RST(rst), .BOOT_MODE_STRAP(boot),
      .HOST_INTERFACE_SELECT(ifs), .ADDR_LSB_SELECT(sa0), .BOOT_DONE(bdone),
      .MOTION_EVENT(mev), .IRQ_FIRST(i1), .IRQ_SECOND(i2), .PIN2_TRIGGER_MODE(trg),
      .IRQ_FIRST_TYPE(t1), .IRQ_SECOND_TYPE(t2), .TYPE_WRITE(twr),
      .SPI_THREE_WIRE(tw3), .SPI_MISO_DATA(mdat), .SPI_MISO_ACTIVE(mact),
      .SERIAL_SDA_DATA(sdat), .SERIAL_SDA_OE(soe), .HIB_REQUEST(hib),
      .CS_N_PIN(csn), .PIN1_IN(p1i), .PIN1_O(p1o), .PIN1_OE(p1oe),
      .PIN2_IN(p2i), .PIN2_O(p2o), .PIN2_OE(p2oe), .MISO_O(mo), .MISO_OE(moe),
      .SDA_O(so), .SDA_OE(sdoe), .MOTION_MODE(mm), .SPI_SELECTED(spi),
      .I2C_ADDR_LSB(lsb), .CHIP_SELECT(cs), .MEASURE_TRIGGER(mt),
      .MOTION_DETECT_EN(mde), .HIBERNATE(hb), .WAKE(wk)
   );

   mpm_host_model HOST
   (
      .clk(clk), .wired(wired), .host_low(hlow), .ext_en(een), .ext_val(ev),
      .d1(d1), .d2(d2), .l1(p1i), .l2(p2i)
   );

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic chk(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic chkn(input int got, input int exp);
      samples_checked++;
      if (got != exp)
      begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chkn

   // Inputs change and outputs are read 2 ns after each rising edge
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #2;
   endtask : cyc

   task automatic do_reset;
      rst = 1'b1;
      cyc(4);
      rst = 1'b0;
      cyc(2);
   endtask : do_reset

   // Allowed drive of a pin asserting its interrupt, per pin type
   function automatic logic ok(input int k, input logic o, input logic oe);
      return k == 0 ? (oe && o) : k == 3 ? !oe : k == 1 ? !(oe && o) : !(oe && !o);
   endfunction : ok

   task automatic summarize;
      $display("errors=%0d checks=%0d", err_count, samples_checked);
      if (err_count == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : summarize

   initial
   begin
      #(25 * 40000);
      err_count++;
      summarize();
   end

   initial
   begin
      {rst, boot, ifs, sa0, bdone, mev, i1, i2, trg, twr, tw3} = 11'h480;
      {mdat, mact, sdat, soe, hib, csn, wired, hlow, een, ev} = 10'h350;
      t1 = mpm_pkg::MPM_PIN_PUSH_PULL;
      t2 = mpm_pkg::MPM_PIN_PUSH_PULL;
      #2;
      do_reset();
      chk(mm, mpm_pkg::BOOT_DEFAULT);
      chk(spi, 1'b0);
      chk(lsb, 1'b1);
      chk(sdoe, 1'b1);
      chk(so, 1'b0);
      chk(mo, 1'b1);
      sa0 = 1'b0;
      cyc(2);
      chk(lsb, 1'b0);
      boot = 1'b1;
      cyc(3);
      chk(mm, 1'b0);
      foreach (rows[k])
      begin
         {i1, i2, trg} = rows[k][6:4];
         cyc(1);
         chk(p1o, rows[k][3]);
         chk(p1oe, rows[k][2]);
         if (!trg) chk(p2o, rows[k][1]);
         chk(p2oe, rows[k][0]);
      end
      {een, ev} = 2'h3;
      for (n = 0; n < 8 && mt !== 1'b1; n++) cyc(1);
      chk(mt, 1'b1);
      ev = 1'b0;
      for (n = 0; n < 8 && mt !== 1'b0; n++) cyc(1);
      chk(mt, 1'b0);
      {een, trg} = 2'h0;
      for (int k = 0; k < 4; k++)
      begin
         t1 = mpm_pkg::mpm_pin_type_t'(k);
         t2 = t1;
         twr = 1'b1;
         cyc(1);
         twr = 1'b0;
         cyc(1);
         chk(ok(k, p1o, p1oe), 1'b1);
         chk(ok(k, p2o, p2oe), 1'b1);
      end
      hib = 1'b1;
      for (n = 0; n < 8 && hb !== 1'b1; n++) cyc(1);
      chk(hb, 1'b1);
      chk(p1oe, 1'b0);
      chk(p2oe, 1'b0);
      chk(sdoe, 1'b0);
      hib = 1'b0;
      cyc(2);
      chk(hb, 1'b1);
      csn = 1'b0;
      for (n = 0; n < 8 && wk !== 1'b1; n++) cyc(1);
      chk(wk, 1'b1);
      chk(hb, 1'b1);
      cyc(1);
      chk(hb, 1'b0);
      chk(p1o, 1'b1);
      chk(p1oe, 1'b1);
      csn = 1'b1;
      ifs = 1'b1;
      do_reset();
      wired = 1'b1;
      chk(mm, mpm_pkg::BOOT_MOTION);
      chk(spi, mpm_pkg::IF_SPI);
      chk(lsb, 1'b0);
      chk(cs, 1'b0);
      chk(p2oe, 1'b1);
      chk(p2o, 1'b0);
      bdone = 1'b1;
      cyc(1);
      chk(p2oe, 1'b0);
      for (n = 0; n < 8 && mde !== 1'b1; n++) cyc(1);
      chk(mde, 1'b1);
      csn = 1'b0;
      for (n = 0; n < 8 && cs !== 1'b1; n++) cyc(1);
      chk(cs, 1'b1);
      chk(moe, 1'b1);
      tw3 = 1'b1;
      cyc(1);
      chk(moe, 1'b0);
      tw3 = 1'b0;
      csn = 1'b1;
      mev = 1'b1;
      cyc(1);
      mev = 1'b0;
      for (n = 0; n < 3 && p1oe !== 1'b1; n++) cyc(1);
      chk(p1o, 1'b0);
      m = 1;
      while (p1oe === 1'b1 && m < mpm_pkg::MOTION_PULSE_CYCLES + 50)
      begin
         cyc(1);
         if (p1oe === 1'b1) m++;
      end
      chkn(m, mpm_pkg::MOTION_PULSE_CYCLES);
      chk(moe, 1'b1);
      hlow = 1'b1;
      for (m = 0; m < mpm_pkg::HIB_ENTRY_CYCLES + 50 && hb !== 1'b1; m++) cyc(1);
      chk(m > mpm_pkg::HIB_ENTRY_CYCLES && m <= mpm_pkg::HIB_ENTRY_CYCLES + 8, 1'b1);
      chk(mde, 1'b0);
      chk(p1oe, 1'b0);
      chk(p2oe, 1'b0);
      chk(moe, 1'b0);
      csn = 1'b0;
      cyc(8);
      chk(hb, 1'b1);
      chk(wk, 1'b0);
      {csn, hlow} = 2'h2;
      for (n = 0; n < 8 && wk !== 1'b1; n++) cyc(1);
      chk(wk, 1'b1);
      cyc(1);
      chk(hb, 1'b0);
      chk(p1oe, 1'b0);
      summarize();
   end
endmodule : mpm_pin_mode_tb_top
